// ---- verilog/pll_config_select_divide.v ----
// pll configuration: runtime control register, config-word load, ratio and frequency model
// assumes an apb master on ref_clk; config words are static straps, sampled after reset release
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pll_cfg_regs.vh"
// Notes on behaviour
// RL1: bit 7 of control picks primary oscillator (0) or internal fast rc (1).
// RL2: reference input from 5 MHz up to 64 MHz is accepted.
// RL3: input divided by three-bit input divider code plus one.
// RL4: range code decodes bypass, five bands, codes 110 and 111 reserved.
// RL5: multiplier is seven-bit field at 22:16 plus one, 1 to 128.
// RL6: output divider at 26:24: 2,4,8,16, and 32 for codes 101-111.
// RL7: config word two holds divider, range, select, multiplier, output divider.
// RL8: secondary oscillator enable comes from bit 6 of config word one.
// RL9: control loads from config word two on the first edge after reset; fout = fin/idiv*mult/odiv.
module pll_config_select_divide #(
  parameter FREQ_W = 32
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // configuration words
  input wire [31:0] config_word_one,
  input wire [31:0] config_word_two,
  // oscillator frequencies in kHz
  input wire [FREQ_W-1:0] primary_oscillator_khz,
  input wire [FREQ_W-1:0] internal_fast_rc_oscillator_khz,
  // pll settings to the analog core
  output reg pll_input_source_select,
  output reg [2:0] pll_input_divider,
  output reg [2:0] pll_input_range,
  output reg [6:0] pll_feedback_multiplier,
  output reg [2:0] pll_output_divider,
  output reg cfg_secondary_osc_enable,
  // derived state
  output reg [FREQ_W-1:0] pll_ref_khz,
  output reg [FREQ_W-1:0] pll_out_khz,
  output reg ref_in_range
);
  localparam ST_LOAD = 1'b0;
  localparam ST_RUN = 1'b1;
  reg state;
  reg next_state;
  reg next_input_source_select;
  reg [2:0] next_input_divider;
  reg [2:0] next_input_range;
  reg [6:0] next_feedback_multiplier;
  reg [2:0] next_output_divider;
  reg next_secondary_osc_enable;
  reg [31:0] next_prdata;

  wire [2:0] cfg_pll_input_divider = config_word_two[`CW2_IDIV_LSB +: 3]; // [RL7]
  wire [2:0] cfg_pll_input_range = config_word_two[`CW2_RNG_LSB +: 3];
  wire cfg_pll_input_source_select = config_word_two[`CW2_ICLK_BIT];
  wire [6:0] cfg_pll_feedback_multiplier = config_word_two[`CW2_MULT_LSB +: 7];
  wire [2:0] cfg_pll_output_divider = config_word_two[`CW2_ODIV_LSB +: 3];
  wire [31:0] system_pll_control = {5'h00, pll_output_divider, 1'b0, pll_feedback_multiplier,
    8'h00, pll_input_source_select, pll_input_range, 1'b0, pll_input_divider};
  wire [3:0] idiv_ratio;
  wire [5:0] odiv_ratio;
  wire [16:0] rng_lo_khz;
  wire [16:0] rng_hi_khz;
  wire rng_bypass;
  wire rng_reserved;
  wire acc = psel & penable;
  wire hit_ctrl = (paddr == `PLL_CTRL_ADDR);
  wire hit_status = (paddr == `PLL_STATUS_ADDR);
  wire hit_one = (paddr == `PLL_CFG_ONE_ADDR);
  wire hit_two = (paddr == `PLL_CFG_TWO_ADDR);
  wire mapped = hit_ctrl | hit_status | hit_one | hit_two;
  wire unmapped = ~mapped;
  wire ro_write = pwrite & ~hit_ctrl;
  wire ctrl_write = acc & pwrite & hit_ctrl;
  // captured in the setup cycle so prdata stands still through the access phase
  wire read_setup = psel & ~penable & ~pwrite;

  // reserved bits of the control word never reach a field
  wire [31:0] masked_wdata = pwdata & `CTL_WMASK;
  wire loaded = (state == ST_RUN);
  wire [31:0] status_word = {29'h00000000, rng_reserved, ref_in_range, loaded};

  // read-only words refuse writes with an error rather than silently dropping them
  // zero wait states: every access phase is answered at once
  assign pready = 1'b1;
  assign pslverr = acc & (unmapped | ro_write);

  // control register: load from config word two, then software owns it
  always @* begin
    // holds by default so a plain read leaves the fields alone
    next_state = state;
    next_input_source_select = pll_input_source_select;
    next_input_divider = pll_input_divider;
    next_input_range = pll_input_range;
    next_feedback_multiplier = pll_feedback_multiplier;
    next_output_divider = pll_output_divider;
    next_secondary_osc_enable = cfg_secondary_osc_enable;
    case (state)
      ST_LOAD: begin
        // one load only; straps that move later are not followed until a reset
        next_state = ST_RUN;
        next_input_source_select = cfg_pll_input_source_select; // [RL9]
        next_input_divider = cfg_pll_input_divider;
        next_input_range = cfg_pll_input_range;
        next_feedback_multiplier = cfg_pll_feedback_multiplier;
        next_output_divider = cfg_pll_output_divider;
        next_secondary_osc_enable = config_word_one[`CW1_SOSC_BIT]; // [RL8]
      end
      ST_RUN: begin
        if (ctrl_write) begin
          next_input_source_select = masked_wdata[`CTL_ICLK_BIT]; // [RL1]
          next_input_divider = masked_wdata[`CTL_IDIV_LSB +: 3];
          next_input_range = masked_wdata[`CTL_RNG_LSB +: 3];
          next_feedback_multiplier = masked_wdata[`CTL_MULT_LSB +: 7]; // [RL5]
          next_output_divider = masked_wdata[`CTL_ODIV_LSB +: 3]; // [RL6]
        end
      end
      default: begin
        next_state = ST_LOAD;
      end
    endcase
  end

  // async reset loads constants only; the straps are copied one edge later
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_LOAD;
      pll_input_source_select <= `CTL_RST_ICLK;
      pll_input_divider <= `CTL_RST_IDIV;
      pll_input_range <= `CTL_RST_RNG;
      pll_feedback_multiplier <= `CTL_RST_MULT;
      pll_output_divider <= `CTL_RST_ODIV;
      cfg_secondary_osc_enable <= `SOSC_RST;
    end else begin
      state <= next_state;
      pll_input_source_select <= next_input_source_select;
      pll_input_divider <= next_input_divider;
      pll_input_range <= next_input_range;
      pll_feedback_multiplier <= next_feedback_multiplier;
      pll_output_divider <= next_output_divider;
      cfg_secondary_osc_enable <= next_secondary_osc_enable;
    end
  end

  pll_ratio_table u_table (
    .ref_clk(ref_clk),
    .rst(rst),
    .idiv_code(pll_input_divider),
    .rng_code(pll_input_range),
    .odiv_code(pll_output_divider),
    .idiv_ratio(idiv_ratio),
    .odiv_ratio(odiv_ratio),
    .rng_lo_khz(rng_lo_khz),
    .rng_hi_khz(rng_hi_khz),
    .rng_bypass(rng_bypass),
    .rng_reserved(rng_reserved)
  );

  // frequency model; divide is costly but the settings change rarely
  // integer kHz: each divide drops the fraction, so the result may read a little low
  // pll_out_khz trails a divider or source write by two edges: ratios or pll_ref_khz, then this register; a multiplier write by one
  wire [FREQ_W-1:0] src_khz = pll_input_source_select ? internal_fast_rc_oscillator_khz
    : primary_oscillator_khz; // [RL1]
  wire [7:0] mult_ratio = {1'b0, pll_feedback_multiplier} + 8'h01; // [RL5]
  wire [FREQ_W-1:0] ref_divided = pll_ref_khz / idiv_ratio; // [RL3]
  wire [FREQ_W+7:0] scaled = ref_divided * mult_ratio;
  wire [FREQ_W+7:0] next_out = scaled / odiv_ratio; // [RL9]
  wire src_ok = (src_khz >= `RNG_MIN_KHZ) && (src_khz <= `RNG_MAX_KHZ); // [RL2]
  // bypass still needs the reference inside the overall input span
  wire in_band = (src_khz >= rng_lo_khz) && (src_khz <= rng_hi_khz);
  wire band_ok = rng_bypass || (!rng_reserved && in_band);
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pll_ref_khz <= {FREQ_W{1'b0}};
      pll_out_khz <= {FREQ_W{1'b0}};
      ref_in_range <= 1'b0;
    end else begin
      pll_ref_khz <= src_khz;
      pll_out_khz <= next_out[FREQ_W-1:0];
      ref_in_range <= src_ok & band_ok; // [RL2]
    end
  end

  // read data
  always @* begin
    case (paddr)
      `PLL_CTRL_ADDR: begin
        next_prdata = system_pll_control;
      end
      `PLL_STATUS_ADDR: begin
        next_prdata = status_word;
      end
      `PLL_CFG_ONE_ADDR: begin
        next_prdata = config_word_one;
      end
      `PLL_CFG_TWO_ADDR: begin
        next_prdata = config_word_two;
      end
      default: begin
        next_prdata = 32'h00000000;
      end
    endcase
  end

  // unmapped reads return zero alongside the error
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (read_setup) begin
      prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/pll_cfg_regs.vh ----
// register offsets, field positions and reset values of the pll configuration block
// assumes inclusion by bare name from design files
`ifndef PLL_CFG_REGS_VH
`define PLL_CFG_REGS_VH
`define PLL_CTRL_ADDR 12'h000
`define PLL_STATUS_ADDR 12'h004
`define PLL_CFG_ONE_ADDR 12'h008
`define PLL_CFG_TWO_ADDR 12'h00C
`define CTL_IDIV_LSB 0
`define CTL_RNG_LSB 4
`define CTL_ICLK_BIT 7
`define CTL_MULT_LSB 16
`define CTL_ODIV_LSB 24
`define CW2_IDIV_LSB 0
`define CW2_RNG_LSB 4
`define CW2_ICLK_BIT 7
`define CW2_MULT_LSB 8
`define CW2_ODIV_LSB 16
`define CW1_SOSC_BIT 6
`define CTL_WMASK 32'h077F00F7
`define CTL_RST_ICLK 1'h0
`define CTL_RST_IDIV 3'h0
`define CTL_RST_RNG 3'h0
`define CTL_RST_MULT 7'h00
`define CTL_RST_ODIV 3'h1
`define SOSC_RST 1'h0
`define RNG_MIN_KHZ 5000
`define RNG_MAX_KHZ 64000
`endif

// ---- verilog/pll_ratio_table.v ----
// registered decode of divider and range codes into plain ratios and limits
// assumes one clock; uses no constants from the register header
`timescale 1ns/1ns
`default_nettype none
module pll_ratio_table (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // codes
  input wire [2:0] idiv_code,
  input wire [2:0] rng_code,
  input wire [2:0] odiv_code,
  // decoded values
  output reg [3:0] idiv_ratio,
  output reg [5:0] odiv_ratio,
  output reg [16:0] rng_lo_khz,
  output reg [16:0] rng_hi_khz,
  output reg rng_bypass,
  output reg rng_reserved
);
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idiv_ratio <= 4'h1;
      odiv_ratio <= 6'h02;
      rng_lo_khz <= 17'h00000;
      rng_hi_khz <= 17'h00000;
      rng_bypass <= 1'b1;
      rng_reserved <= 1'b0;
    end else begin
      idiv_ratio <= {1'b0, idiv_code} + 4'h1; // [RL3]
      case (odiv_code) // [RL6]
        3'h1: odiv_ratio <= 6'h02;
        3'h2: odiv_ratio <= 6'h04;
        3'h3: odiv_ratio <= 6'h08;
        3'h4: odiv_ratio <= 6'h10;
        3'h0: odiv_ratio <= 6'h02; // code 0 undocumented, treated as the smallest divide
        default: odiv_ratio <= 6'h20;
      endcase
      rng_bypass <= (rng_code == 3'h0);
      rng_reserved <= (rng_code[2:1] == 2'h3);
      case (rng_code) // [RL4]
        3'h1: begin
          rng_lo_khz <= 17'd5000;
          rng_hi_khz <= 17'd10000;
        end
        3'h2: begin
          rng_lo_khz <= 17'd8000;
          rng_hi_khz <= 17'd16000;
        end
        3'h3: begin
          rng_lo_khz <= 17'd13000;
          rng_hi_khz <= 17'd26000;
        end
        3'h4: begin
          rng_lo_khz <= 17'd21000;
          rng_hi_khz <= 17'd42000;
        end
        3'h5: begin
          rng_lo_khz <= 17'd34000;
          rng_hi_khz <= 17'd64000;
        end
        default: begin
          rng_lo_khz <= 17'h00000;
          rng_hi_khz <= 17'h00000;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verif/pll_cfg_checker.sv ----
// checker: control field load, write and hold relations, bus answers
// assumes bind onto pll_config_select_divide, one clock domain
`timescale 1ns/1ns
`default_nettype none
module pll_cfg_checker (
  // clock, reset, bus
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // straps and fields
  input wire [31:0] config_word_one,
  input wire [31:0] config_word_two,
  input wire pll_input_source_select,
  input wire [2:0] pll_input_divider,
  input wire [2:0] pll_input_range,
  input wire [6:0] pll_feedback_multiplier,
  input wire [2:0] pll_output_divider,
  input wire cfg_secondary_osc_enable
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  wire wr = psel && penable && pwrite && paddr == 12'h000;
  wire [16:0] fv = {pll_output_divider, pll_feedback_multiplier, pll_input_source_select,
    pll_input_range, pll_input_divider};
  wire [16:0] wf = {pwdata[26:24], pwdata[22:16], pwdata[7:4], pwdata[2:0]};
  wire [16:0] cv = {config_word_two[18:16], config_word_two[14:8], config_word_two[7:4],
    config_word_two[2:0]};
  AST_LOAD: assert property ($fell(rst) |=> fv == cv)
    else $error("control not loaded from config word");
  AST_SOSC: assert property ($fell(rst) |=>
    (cfg_secondary_osc_enable == config_word_one[6])[*4])
    else $error("secondary osc enable wrong");
  AST_WRITE: assert property (wr |=> fv == $past(wf))
    else $error("control write not taken");
  AST_HOLD: assert property (!wr && !$fell(rst) |=> $stable(fv))
    else $error("control changed without write");
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access not answered");
  AST_BADADDR: assert property (psel && penable && paddr == 12'h010 |-> pslverr)
    else $error("unmapped access without error");
  AST_ROWRITE: assert property (psel && penable && pwrite && paddr == 12'h008 |-> pslverr)
    else $error("read-only write without error");
  AST_OKREAD: assert property (psel && penable && paddr == 12'h000 |-> !pslverr)
    else $error("control access flagged");
endmodule
bind pll_config_select_divide pll_cfg_checker u_chk (.ref_clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .config_word_one, .config_word_two,
  .pll_input_source_select, .pll_input_divider, .pll_input_range,
  .pll_feedback_multiplier, .pll_output_divider, .cfg_secondary_osc_enable);
`default_nettype wire

// ---- verif/testbench.sv ----
// bench: apb traffic, queued read and frequency expectations
// assumes the pll configuration design with its checker bound
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, cw1 = '0, cw2 = '0, primary_oscillator = '0, internal_fast_rc_oscillator = '0, ctl, wd;
  logic pready, in_range;
  logic [31:0] prdata, pll_out_khz, ref_khz, st;
  logic [31:0] q[$], qf[$], qr[$], qs[$];
  // band limits in kHz by range code; code 0 spans the whole input, 6 and 7 match nothing
  logic [31:0] band_lo[8] = '{32'h1388, 32'h1388, 32'h1F40, 32'h32C8, 32'h5208, 32'h84D0,
    32'hFFFFFFFF, 32'hFFFFFFFF};
  logic [31:0] band_hi[8] = '{32'hFA00, 32'h2710, 32'h3E80, 32'h6590, 32'hA410, 32'hFA00,
    32'h0, 32'h0};
  int bad_count = 0;
  int samples_checked = 0;
  always #2 ref_clk = ~ref_clk;
  pll_config_select_divide DUT (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr(), .config_word_one(cw1), .config_word_two(cw2),
    .primary_oscillator_khz(primary_oscillator), .internal_fast_rc_oscillator_khz(internal_fast_rc_oscillator),
    .pll_input_source_select(), .pll_input_divider(), .pll_input_range(),
    .pll_feedback_multiplier(), .pll_output_divider(), .cfg_secondary_osc_enable(),
    .pll_ref_khz(ref_khz), .pll_out_khz, .ref_in_range(in_range));
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // request stays up after the answer so a following setup can reuse psel
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      bad_count++;
      report_and_stop;
    end
  endtask
  task rel;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(1'h0, a, 32'h0);
  endtask
  function logic [31:0] fexp(input logic [31:0] c);
    logic [31:0] r;
    logic [31:0] o;
    r = c[7] ? internal_fast_rc_oscillator : primary_oscillator;
    o = c[26:24] == 3'h0 ? 32'h2 : (c[26:24] > 3'h4 ? 32'h20 : 32'h1 << c[26:24]);
    return r / (c[2:0] + 32'h1) * (c[22:16] + 32'h1) / o;
  endfunction
  // status word: bit2 reserved range code, bit1 reference in range, bit0 loaded
  function logic [31:0] sexp(input logic [31:0] c);
    logic [31:0] r;
    r = c[7] ? internal_fast_rc_oscillator : primary_oscillator;
    return {29'h0, c[6:5] == 2'h3, r >= band_lo[c[6:4]] && r <= band_hi[c[6:4]]
      && r >= 32'h1388 && r <= 32'hFA00, 1'h1};
  endfunction
  task note_out(input logic [31:0] c);
    st = sexp(c);
    qf.push_back(fexp(c));
    qr.push_back(c[7] ? internal_fast_rc_oscillator : primary_oscillator);
    qs.push_back({31'h0, st[1]});
  endtask
  always @(posedge ref_clk)
    if (psel && penable && !pwrite && pready && q.size() > 0)
      chk("prdata", q.pop_front(), prdata);
  // negedge: frequency output long settled, no race with the edge
  always @(negedge ref_clk)
    if (qf.size() > 0) begin
      chk("pll_out_khz", qf.pop_front(), pll_out_khz);
      chk("pll_ref_khz", qr.pop_front(), ref_khz);
      chk("ref_in_range", qs.pop_front(), {31'h0, in_range});
    end
  initial begin
    void'($urandom(32'hB5A7));
    cw1 = $urandom;
    cw2 = $urandom;
    primary_oscillator = 32'h1388 + $urandom % 32'hE679;
    internal_fast_rc_oscillator = 32'h1388 + $urandom % 32'hE679;
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (2) @(posedge ref_clk);
    ctl = {5'h0, cw2[18:16], 1'h0, cw2[14:8], 8'h0, cw2[7:4], 1'h0, cw2[2:0]};
    rd(12'h000, ctl);
    rd(12'h008, cw1);
    apb(1'h1, 12'h008, ~cw1);
    rd(12'h008, cw1);
    rd(12'h010, 32'h0);
    rel;
    note_out(ctl);
    for (int i = 0; i < 16; i++) begin
      primary_oscillator <= 32'h1388 + $urandom % 32'hE679;
      internal_fast_rc_oscillator <= 32'h1388 + $urandom % 32'hE679;
      wd = $urandom;
      wd[26:24] = i[2:0];
      wd[7] = i[3];
      wd[6:4] = i[2:0];
      wd[2:0] = ~i[2:0];
      if (i < 2) wd[22:16] = {7{i[0]}};
      ctl = wd & 32'h077F00F7;
      apb(1'h1, 12'h000, wd);
      rd(12'h000, ctl);
      rel;
      repeat (3) @(posedge ref_clk);
      rd(12'h004, sexp(ctl));
      rel;
      note_out(ctl);
    end
    @(posedge ref_clk);
    report_and_stop;
  end
endmodule
`default_nettype wire
